// ==== rtl/osc_params.svh ====
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH
// ==========================================
// register offsets
`define OSC_OFF_MCLK_SEL 8'h00
`define OSC_OFF_PRESCALER 8'h01
`define OSC_OFF_LOCK 8'h02
`define OSC_OFF_STATUS 8'h03
`define OSC_OFF_MAIN_CTRL 8'h10
`define OSC_OFF_TRIM_A 8'h11
`define OSC_OFF_TRIM_B 8'h12
`define OSC_OFF_ULP_CTRL 8'h18
`define OSC_OFF_XTAL_CTRL 8'h1C
`define OSC_OFF_CHG_PROT 8'h34
`define OSC_OFF_ERR_LOW_V 8'h40
`define OSC_OFF_ERR_HIGH_V 8'h41
// ==========================================
// reset values and keys
`define OSC_RST_MCLK_SEL 8'h00
`define OSC_RST_PRESCALER 8'h11
`define OSC_IO_UNLOCK_KEY 8'hD8
`define OSC_UNLOCK_WINDOW 3'h4
// ==========================================
// field positions
`define OSC_XTAL_ENABLE 0
`define OSC_XTAL_SEL 2
`define OSC_XTAL_CRYSTAL_STARTUP_COUNT_LO 4
`define OSC_TRIMB_LOCK 7
// ==========================================
// timing counts
`define OSC_EXTRA_CYCLES 4
`define OSC_PIN_CLK_CYCLES 2
`define OSC_MAIN_ANALOG_NS 12000
`define OSC_ULP_ANALOG_NS 250000
`define OSC_CLK_NS 10
`define OSC_TICK_1K_NS 1000000
`endif

// ==== rtl/osc_pkg.sv ====
package osc_pkg;
   typedef enum logic [1:0] {
      OSC_SRC_MAIN, OSC_SRC_ULP, OSC_SRC_XTAL, OSC_SRC_PIN
   } osc_src_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } osc_bus_type;
   typedef struct packed {
      logic main_rc;
      logic ulp_rc;
      logic crystal;
      logic pin_clock;
   } osc_req_type;
endpackage : osc_pkg

// ==== rtl/osc_startup.sv ====
`timescale 1ns/1ns
`default_nettype none
module osc_startup #(
   parameter int CW = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // control
   input wire logic request,
   input wire logic osc_edge,
   input wire logic [CW-1:0] analog_cycles,
   input wire logic [CW-1:0] edge_count,
   // status
   output logic stable
);
   typedef enum logic [1:0] {ST_OFF, ST_ANALOG, ST_EDGES, ST_ON} osc_state_type;
   osc_state_type state_q;
   logic [CW-1:0] count_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= ST_OFF;
         count_q <= '0;
      end else if (!request) begin
         state_q <= ST_OFF;
         count_q <= '0;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               state_q <= (analog_cycles == '0) ? ST_EDGES : ST_ANALOG;
               count_q <= '0;
            end
            ST_ANALOG: begin
               if (count_q + 1'b1 >= analog_cycles) begin
                  state_q <= ST_EDGES;
                  count_q <= '0;
               end else begin
                  count_q <= count_q + 1'b1;
               end
            end
            ST_EDGES: begin
               if (osc_edge) begin
                  if (count_q + 1'b1 >= edge_count) begin
                     state_q <= ST_ON;
                  end
                  count_q <= count_q + 1'b1;
               end
            end
            ST_ON: count_q <= count_q;
         endcase
      end
   end
   assign stable = (state_q == ST_ON);
endmodule : osc_startup
`default_nettype wire

// ==== rtl/osc_sources.sv ====
// Function
// - fuse trims loaded into fields at reset
// - center and slope trims drive oscillator
// - frequency select fuse sets reset frequency
// - trim lock fuse blocks trim writes
// - main lock with main source blocks trims
// - trims writable only after unlock
// - main ready after analog plus four
// - signature error bytes for 3V, 5V
// - error byte is compressed Q1.10
// - ulp oscillator gives 1 kHz tick
// - ulp ready after startup plus four
// - select bit picks crystal or external clock
// - enable takes pins, gates start
// - startup count field sets crystal wait
// - external clock on crystal pin: two
// - pin source request switches pin mode
// - pin source ready after two cycles
// - unlock key then write within four
// - unprotected write leaves register unchanged
// - all control registers need unlock key
// - reset: main rc, prescale by six
//
// Implementation choices: strobed register access and the register addresses.
`include "osc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module osc_sources
   import osc_pkg::*;
#(
   parameter int MAIN_ANALOG_NS = `OSC_MAIN_ANALOG_NS,
   parameter int ULP_ANALOG_NS = `OSC_ULP_ANALOG_NS,
   parameter int TICK_NS = `OSC_TICK_1K_NS,
   parameter logic [7:0] ERR_LOW_V = 8'h00,
   parameter logic [7:0] ERR_HIGH_V = 8'h00
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire osc_bus_type bus,
   output logic [7:0] rdata,
   // fuses
   input wire logic [6:0] fuse_center_trim,
   input wire logic [3:0] fuse_temp_trim,
   input wire logic [1:0] freq_select_fuse,
   input wire logic trim_lock_fuse,
   // clock requests and oscillator edges
   input wire osc_req_type req,
   input wire logic main_edge,
   input wire logic ulp_edge,
   input wire logic crystal_edge,
   input wire logic pin_edge,
   // oscillator controls
   output logic [6:0] center_freq_trim,
   output logic [3:0] temp_slope_trim,
   output logic [1:0] main_freq_select,
   output logic [1:0] main_clock_source,
   output logic [4:0] prescaler_setting,
   output logic crystal_run,
   output logic crystal_ext_clock,
   output logic crystal_pins_taken,
   output logic pin_clock_mode,
   output logic ulp_tick_1k,
   output logic [3:0] ready
);
   // ==========================================
   // timing
   localparam int MAIN_CYC = (MAIN_ANALOG_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS;
   localparam int ULP_CYC = (ULP_ANALOG_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS;
   localparam int TICK_CYC = TICK_NS / `OSC_CLK_NS;
   // ==========================================
   // state
   logic [7:0] mclk_sel_q, prescaler_q, main_ctrl_q, ulp_ctrl_q, xtal_ctrl_q;
   logic [6:0] trim_a_q;
   logic [3:0] trim_b_q;
   logic trim_lock_q, clk_lock_q, fuse_lock_q, fuse_taken_q;
   logic [1:0] freq_sel_q;
   logic [2:0] unlock_q;
   logic [7:0] rdata_q;
   logic [19:0] tick_cnt_q;
   logic tick_q;
   logic [3:0] ready_q;
   logic [3:0] stable_w;
   // ==========================================
   // decode
   wire unlocked_w = (unlock_q != 3'h0);
   wire key_w = bus.wr && (bus.addr == `OSC_OFF_CHG_PROT) && (bus.wdata == `OSC_IO_UNLOCK_KEY);
   wire prot_wr_w = bus.wr && unlocked_w;
   wire main_locked_w = clk_lock_q;
   wire trim_blocked_w = fuse_lock_q || trim_lock_q
      || (main_locked_w && mclk_sel_q[1:0] == OSC_SRC_MAIN);
   wire trim_ok_w = prot_wr_w && !trim_blocked_w;
   wire mclk_ok_w = prot_wr_w && !main_locked_w;
   wire xtal_en_w = xtal_ctrl_q[`OSC_XTAL_ENABLE];
   wire [3:0] want_w = {req.pin_clock, req.crystal && xtal_en_w,
      req.ulp_rc || ulp_ctrl_q[1], req.main_rc || main_ctrl_q[1]};
   wire [15:0] xtal_wait_w = xtal_ctrl_q[`OSC_XTAL_SEL] ? 16'(`OSC_PIN_CLK_CYCLES)
      : (16'h0400 << xtal_ctrl_q[5:4]);
   // ==========================================
   // unlock window: the key write opens it for OSC_UNLOCK_WINDOW clock cycles, counted down every cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         unlock_q <= 3'h0;
      end else if (key_w) begin
         unlock_q <= `OSC_UNLOCK_WINDOW;
      end else if (unlocked_w) begin
         unlock_q <= unlock_q - 3'h1;
      end
   end
   // ==========================================
   // fuses are sampled at the first edge after reset release
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fuse_taken_q <= 1'b0;
         fuse_lock_q <= 1'b0;
         freq_sel_q <= 2'h0;
      end else if (!fuse_taken_q) begin
         fuse_taken_q <= 1'b1;
         fuse_lock_q <= trim_lock_fuse;
         freq_sel_q <= freq_select_fuse;
      end
   end
   // ==========================================
   // control registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mclk_sel_q <= `OSC_RST_MCLK_SEL;
         prescaler_q <= `OSC_RST_PRESCALER;
         clk_lock_q <= 1'b0;
         main_ctrl_q <= 8'h00;
         ulp_ctrl_q <= 8'h00;
         xtal_ctrl_q <= 8'h00;
         trim_a_q <= 7'h00;
         trim_b_q <= 4'h0;
         trim_lock_q <= 1'b0;
      end else if (!fuse_taken_q) begin
         trim_a_q <= fuse_center_trim;
         trim_b_q <= fuse_temp_trim;
         clk_lock_q <= trim_lock_fuse;
      end else if (prot_wr_w) begin
         unique case (bus.addr)
            `OSC_OFF_MCLK_SEL: if (mclk_ok_w) mclk_sel_q <= bus.wdata & 8'h83;
            `OSC_OFF_PRESCALER: if (mclk_ok_w) prescaler_q <= bus.wdata & 8'h1F;
            `OSC_OFF_LOCK: if (!main_locked_w) clk_lock_q <= bus.wdata[0];
            `OSC_OFF_MAIN_CTRL: main_ctrl_q <= bus.wdata & 8'h02;
            `OSC_OFF_ULP_CTRL: ulp_ctrl_q <= bus.wdata & 8'h02;
            `OSC_OFF_XTAL_CTRL: xtal_ctrl_q <= bus.wdata & 8'h37;
            `OSC_OFF_TRIM_A: if (trim_ok_w) trim_a_q <= bus.wdata[6:0];
            `OSC_OFF_TRIM_B: if (trim_ok_w) begin
               trim_b_q <= bus.wdata[3:0];
               trim_lock_q <= bus.wdata[`OSC_TRIMB_LOCK];
            end
            default: ;
         endcase
      end
   end
   // ==========================================
   // start-up counters, one per source
   wire [63:0] analog_w = {16'h0000, 16'h0000, 16'(ULP_CYC), 16'(MAIN_CYC)};
   wire [63:0] edges_w = {16'(`OSC_PIN_CLK_CYCLES), xtal_wait_w,
      16'(`OSC_EXTRA_CYCLES), 16'(`OSC_EXTRA_CYCLES)};
   wire [3:0] edge_w = {pin_edge, crystal_edge, ulp_edge, main_edge};
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_osc
         osc_startup #(.CW(16)) u_start (
            .clock(clock),
            .rst(rst),
            .request(want_w[g]),
            .osc_edge(edge_w[g]),
            .analog_cycles(analog_w[g*16 +: 16]),
            .edge_count(edges_w[g*16 +: 16]),
            .stable(stable_w[g])
         );
      end
   endgenerate
   // ==========================================
   // 1 kHz tick from the ulp oscillator, only while it is ready
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 20'h00000;
         tick_q <= 1'b0;
      end else if (!stable_w[1]) begin
         tick_cnt_q <= 20'h00000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 20'(TICK_CYC - 1)) begin
         tick_cnt_q <= 20'h00000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 20'h00001;
         tick_q <= 1'b0;
      end
   end
   // ==========================================
   // read port
   wire [7:0] status_w = {ready_q[3], ready_q[2], ready_q[1], ready_q[0], 4'h0};
   logic [7:0] rsel_w;
   always_comb begin
      unique case (bus.addr)
         `OSC_OFF_MCLK_SEL: rsel_w = mclk_sel_q;
         `OSC_OFF_PRESCALER: rsel_w = prescaler_q;
         `OSC_OFF_LOCK: rsel_w = {7'h00, clk_lock_q};
         `OSC_OFF_STATUS: rsel_w = status_w;
         `OSC_OFF_MAIN_CTRL: rsel_w = main_ctrl_q;
         `OSC_OFF_TRIM_A: rsel_w = {1'b0, trim_a_q};
         `OSC_OFF_TRIM_B: rsel_w = {trim_lock_q, 3'h0, trim_b_q};
         `OSC_OFF_ULP_CTRL: rsel_w = ulp_ctrl_q;
         `OSC_OFF_XTAL_CTRL: rsel_w = xtal_ctrl_q;
         `OSC_OFF_ERR_LOW_V: rsel_w = ERR_LOW_V;
         `OSC_OFF_ERR_HIGH_V: rsel_w = ERR_HIGH_V;
         default: rsel_w = 8'h00;
      endcase
   end
   // ==========================================
   // registered outputs
   logic [6:0] ctr_q;
   logic [3:0] tmp_q;
   logic [1:0] fsel_q, src_q;
   logic [4:0] psc_q;
   logic xrun_q, xext_q, xpin_q, pmode_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
         ready_q <= 4'h0;
         ctr_q <= 7'h00;
         tmp_q <= 4'h0;
         fsel_q <= 2'h0;
         src_q <= 2'h0;
         psc_q <= 5'h11;
         xrun_q <= 1'b0;
         xext_q <= 1'b0;
         xpin_q <= 1'b0;
         pmode_q <= 1'b0;
      end else begin
         rdata_q <= bus.rd ? rsel_w : 8'h00;
         ready_q <= stable_w & want_w;
         ctr_q <= trim_a_q;
         tmp_q <= trim_b_q;
         fsel_q <= freq_sel_q;
         src_q <= mclk_sel_q[1:0];
         psc_q <= prescaler_q[4:0];
         xrun_q <= want_w[2];
         xext_q <= xtal_ctrl_q[`OSC_XTAL_SEL];
         xpin_q <= xtal_en_w;
         pmode_q <= req.pin_clock;
      end
   end
   assign rdata = rdata_q;
   assign ready = ready_q;
   assign center_freq_trim = ctr_q;
   assign temp_slope_trim = tmp_q;
   assign main_freq_select = fsel_q;
   assign main_clock_source = src_q;
   assign prescaler_setting = psc_q;
   assign crystal_run = xrun_q;
   assign crystal_ext_clock = xext_q;
   assign crystal_pins_taken = xpin_q;
   assign pin_clock_mode = pmode_q;
   assign ulp_tick_1k = tick_q;
endmodule : osc_sources
`default_nettype wire

// ==== verif/osc_pins_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// =====
// crystal and clock-pin partner
module osc_pins_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pin takeover from the block
   input wire logic xtal_run,
   input wire logic pin_mode,
   // edges seen by the block
   output logic xtal_edge,
   output logic pin_edge
);
   logic [1:0] xc_q;
   logic [1:0] pc_q;
   // no edges unless the pins were handed over: a parked crystal never rings
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         xc_q <= 2'h0;
         pc_q <= 2'h0;
      end else begin
         xc_q <= xtal_run ? xc_q + 2'h1 : 2'h0;
         pc_q <= pin_mode ? pc_q + 2'h1 : 2'h0;
      end
   end
   assign xtal_edge = xtal_run && xc_q == 2'h3;
   assign pin_edge = pin_mode && pc_q == 2'h3;
endmodule : osc_pins_model
`default_nettype wire

// ==== verif/osc_sources_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// =====
// port checks
module osc_chk
   import osc_pkg::*;
#(
   parameter logic [7:0] ERR_LOW_V = 8'h00,
   parameter logic [7:0] ERR_HIGH_V = 8'h00
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // watched
   input wire osc_bus_type bus,
   input wire logic [7:0] rdata,
   input wire osc_req_type req,
   input wire logic [1:0] main_clock_source,
   input wire logic [4:0] prescaler_setting,
   input wire logic crystal_run,
   input wire logic crystal_pins_taken,
   input wire logic pin_clock_mode,
   input wire logic ulp_tick_1k,
   input wire logic [3:0] ready
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_reset_div_six: assert property (
      $fell(rst) |-> main_clock_source == 2'h0 && prescaler_setting == 5'h11)
      else $error("bad reset clock");
   a_pins_gate_run: assert property (
      crystal_run |-> crystal_pins_taken)
      else $error("crystal runs without pins");
   a_pin_mode_on: assert property (
      $rose(req.pin_clock) |=> pin_clock_mode)
      else $error("pin not switched");
   a_pin_ready_late: assert property (
      $rose(ready[3]) |-> $past(req.pin_clock, 2))
      else $error("pin ready too early");
   a_pin_ready_drop: assert property (
      $fell(req.pin_clock) |-> ##[0:3] !ready[3])
      else $error("pin ready kept");
   a_tick_needs_ulp: assert property (
      ulp_tick_1k |-> ready[1] || $past(ready[1]))
      else $error("tick without ulp");
   a_tick_gap: assert property (
      ulp_tick_1k |=> !ulp_tick_1k [*8])
      else $error("tick too fast");
   a_err_bytes: assert property (
      $past(bus.rd) && $past(bus.addr[7:1]) == 7'h20
         |-> rdata == ($past(bus.addr[0]) ? ERR_HIGH_V : ERR_LOW_V))
      else $error("bad error byte");
endmodule : osc_chk
bind osc_sources osc_chk #(.ERR_LOW_V(ERR_LOW_V), .ERR_HIGH_V(ERR_HIGH_V)) chk_i (
   .clock, .rst, .bus, .rdata, .req, .main_clock_source, .prescaler_setting,
   .crystal_run, .crystal_pins_taken, .pin_clock_mode, .ulp_tick_1k, .ready);
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
   import osc_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   osc_bus_type bus = '0;
   osc_req_type req = '0;
   logic tlf = 1'b0;
   logic [6:0] fct = 7'h2A;
   logic [3:0] ftt = 4'h5;
   logic [1:0] fsf = 2'h1;
   logic [1:0] ph = 2'h0;
   logic [7:0] rdata;
   logic [6:0] center_freq_trim;
   logic [3:0] temp_slope_trim;
   logic [1:0] main_freq_select;
   logic [4:0] prescaler_setting;
   logic crystal_run;
   logic crystal_ext_clock;
   logic crystal_pins_taken;
   logic pin_clock_mode;
   logic ulp_tick_1k;
   logic [3:0] ready;
   logic xe;
   logic pe;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   // =====
   // block and partner
   osc_sources #(.MAIN_ANALOG_NS(50), .ULP_ANALOG_NS(50), .TICK_NS(200),
      .ERR_LOW_V(8'hF6), .ERR_HIGH_V(8'h0C)) dut (
      .clock, .rst, .bus, .rdata, .fuse_center_trim(fct), .fuse_temp_trim(ftt),
      .freq_select_fuse(fsf), .trim_lock_fuse(tlf), .req, .main_edge(ph[0]),
      .ulp_edge(ph == 2'h0), .crystal_edge(xe), .pin_edge(pe), .center_freq_trim,
      .temp_slope_trim, .main_freq_select, .main_clock_source(), .prescaler_setting,
      .crystal_run, .crystal_ext_clock, .crystal_pins_taken, .pin_clock_mode,
      .ulp_tick_1k, .ready);
   osc_pins_model pm (.clock, .rst, .xtal_run(crystal_run), .pin_mode(pin_clock_mode),
      .xtal_edge(xe), .pin_edge(pe));
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      ph <= ph + 2'h1;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         end_of_test();
      end
   end
   // =====
   // helpers
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic do_reset(input logic lf);
      rst <= 1'b1;
      tlf <= lf;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : do_reset
   // a gap cycle after each write keeps every strobe a single pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus <= '0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus <= '0;
      #1;
      chk($sformatf("reg %h", a), rdata, e);
      @(posedge clock);
   endtask : rd
   task automatic key;
      wr(8'h34, 8'hD8);
   endtask : key
   task automatic rise(input int b, input int lo, input int hi);
      int n;
      n = 0;
      #1;
      while (ready[b] !== 1'b1 && n < hi) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk("ready delay", {7'h0, n >= lo && n < hi}, 8'h01);
   endtask : rise
   // =====
   // scenarios
   task automatic t_reset;
      #1;
      chk("center trim", {1'b0, center_freq_trim}, 8'h2A);
      chk("slope trim", {4'h0, temp_slope_trim}, 8'h05);
      chk("freq select", {6'h0, main_freq_select}, 8'h01);
      chk("prescaler", {3'h0, prescaler_setting}, 8'h11);
      @(posedge clock);
      rd(8'h12, 8'h05);
      rd(8'h00, 8'h00);
   endtask : t_reset
   task automatic t_protect;
      wr(8'h11, 8'h55);
      rd(8'h11, 8'h2A);
      key();
      wr(8'h01, 8'h05);
      rd(8'h01, 8'h05);
      key();
      wr(8'h11, 8'h55);
      rd(8'h11, 8'h55);
      #1;
      chk("center trim", {1'b0, center_freq_trim}, 8'h55);
      @(posedge clock);
      key();
      repeat (2) @(posedge clock);
      wr(8'h11, 8'h33);
      rd(8'h11, 8'h33);
      key();
      repeat (3) @(posedge clock);
      wr(8'h11, 8'h44);
      rd(8'h11, 8'h33);
      wr(8'h1C, 8'h01);
      rd(8'h1C, 8'h00);
      key();
      wr(8'h01, 8'h11);
   endtask : t_protect
   task automatic t_lock;
      key();
      wr(8'h02, 8'h01);
      key();
      wr(8'h11, 8'h77);
      rd(8'h11, 8'h33);
      key();
      wr(8'h01, 8'h05);
      rd(8'h01, 8'h11);
      do_reset(1'b1);
      key();
      wr(8'h11, 8'h66);
      rd(8'h11, 8'h2A);
      do_reset(1'b0);
      rd(8'h40, 8'hF6);
      rd(8'h41, 8'h0C);
      chk("comp baud", 8'(74 * (1024 - 10) / 1024), 8'h49);
   endtask : t_lock
   task automatic t_osc;
      int n;
      n = 0;
      req.main_rc <= 1'b1;
      rise(0, 10, 30);
      @(posedge clock);
      req.ulp_rc <= 1'b1;
      rise(1, 16, 60);
      repeat (100) begin
         @(posedge clock);
         #1;
         n += int'(ulp_tick_1k);
      end
      chk("ticks", n[7:0], 8'h05);
      @(posedge clock);
      req.main_rc <= 1'b0;
      req.crystal <= 1'b1;
      repeat (50) @(posedge clock);
      #1;
      chk("main ready", {7'h0, ready[0]}, 8'h00);
      chk("crystal ready", {7'h0, ready[2]}, 8'h00);
      @(posedge clock);
      key();
      wr(8'h1C, 8'h05);
      rise(2, 3, 60);
      chk("pins", {6'h0, crystal_pins_taken, crystal_ext_clock}, 8'h03);
      @(posedge clock);
      rd(8'h03, 8'h60);
      req.crystal <= 1'b0;
      key();
      wr(8'h1C, 8'h01);
      req.crystal <= 1'b1;
      repeat (200) @(posedge clock);
      #1;
      chk("crystal ready", {7'h0, ready[2]}, 8'h00);
      @(posedge clock);
      req.pin_clock <= 1'b1;
      rise(3, 4, 30);
      @(posedge clock);
      req.pin_clock <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : t_osc
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   initial begin
      do_reset(1'b0);
      t_reset();
      t_protect();
      t_lock();
      t_osc();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
